// file: acfi_pkg.sv
//======================================================================
// Operation
// RULE_01: code 34 copies accumulator to axis parameter
// RULE_02: code 35 copies accumulator to global parameter
// RULE_03: global bank 2 stores into user variables
// RULE_04: accumulator persists across instructions, never reset; presetn here loads ACFI_ACCU_RST
// RULE_05: code 36 clears flags; type 0 all
// RULE_06: types 1..5 clear single named flags
// RULE_07: code 25 enables interrupt given by type
// RULE_08: interrupt number 255 enables processing globally
// RULE_09: enable ignores motor/bank and value fields
// RULE_10: executed frame replies status 100, value meaningless
// RULE_11: frame order: address, code, type, bank, value, checksum
// RULE_12: checksum is byte sum; mismatches discarded
// RULE_13: execute only when target address matches own
package acfi_pkg;

  //====================================================================
  // register map, byte addresses
  localparam logic [7:0] ACFI_OFS_CTRL      = 8'h00;
  localparam logic [7:0] ACFI_OFS_FRAME     = 8'h04;
  localparam logic [7:0] ACFI_OFS_ACCU      = 8'h08;
  localparam logic [7:0] ACFI_OFS_REPLY     = 8'h0C;
  localparam logic [7:0] ACFI_OFS_ERR       = 8'h10;
  localparam logic [7:0] ACFI_OFS_IRQ_EN    = 8'h14;
  localparam logic [7:0] ACFI_OFS_IRQ_GLB   = 8'h18;
  localparam logic [7:0] ACFI_OFS_EVT_STAT  = 8'h1C;
  localparam logic [7:0] ACFI_OFS_EVT_MASK  = 8'h20;
  localparam logic [7:0] ACFI_OFS_UVAR_ADDR = 8'h24;
  localparam logic [7:0] ACFI_OFS_UVAR_DATA = 8'h28;

  //====================================================================
  // field positions and reset values
  localparam int         ACFI_CTRL_ABORT_BIT = 8;
  localparam logic [7:0] ACFI_MOD_ADDR_RST   = 8'h01;
  localparam logic [31:0] ACFI_ACCU_RST      = 32'h0000_0000;
  localparam int         ACFI_EVT_REPLY      = 0;
  localparam int         ACFI_EVT_DROP       = 1;
  localparam int         ACFI_EVT_ERRSET     = 2;
  localparam int         ACFI_EVT_W          = 3;
  localparam int         ACFI_ERR_W          = 5;
  localparam int         ACFI_NUM_IRQ        = 32;
  localparam int         ACFI_UVAR_DEPTH     = 256;

  //====================================================================
  // frame and instruction set
  localparam logic [3:0] ACFI_FRAME_LAST     = 4'd8;
  localparam logic [7:0] ACFI_INS_AXIS       = 8'd34;
  localparam logic [7:0] ACFI_INS_GLOBAL     = 8'd35;
  localparam logic [7:0] ACFI_INS_CLEAR      = 8'd36;
  localparam logic [7:0] ACFI_INS_IRQ_EN     = 8'd25;
  localparam logic [7:0] ACFI_UVAR_BANK      = 8'd2;
  localparam logic [7:0] ACFI_IRQ_GLOBAL_NUM = 8'd255;
  localparam logic [7:0] ACFI_CLE_ALL        = 8'd0;
  localparam logic [7:0] ACFI_CLE_MAX        = 8'd5;
  localparam logic [7:0] ACFI_STAT_OK        = 8'd100;
  localparam logic [7:0] ACFI_STAT_BAD_CMD   = 8'd2;
  localparam logic [7:0] ACFI_STAT_BAD_TYPE  = 8'd3;

  typedef enum logic [0:0] {
    ACFI_COLLECT,
    ACFI_EXEC
  } acfi_state_type;

endpackage

// file: acfi_uvar_mem.sv
module acfi_uvar_mem
  import acfi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [7:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [7:0]  raddr,
  output logic      [31:0] rdata
);

  typedef struct packed {
    logic [ACFI_UVAR_DEPTH-1:0][31:0] word;
    logic [31:0]                      rdata;
  } acfi_mem_state_type;

  acfi_mem_state_type q;
  acfi_mem_state_type d;

  always_comb begin
    d = q;
    if (we) begin
      d.word[waddr] = wdata;
    end
    // read is of the stored word; a same-cycle write shows one cycle later
    d.rdata = q.word[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata = q.rdata;

endmodule

// file: acfi_core.sv
// The register offsets and the APB interface to the registers were left to the implementer.
module acfi_core
  import acfi_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    accu_load_valid,
  input  wire logic [31:0]             accu_load_data,
  input  wire logic [ACFI_ERR_W-1:0]   err_set,
  output logic      [ACFI_ERR_W-1:0]   err_flags,
  output logic      [ACFI_NUM_IRQ-1:0] irq_src_en,
  output logic                         irq_global_en,
  output logic                         axis_wr_valid,
  output logic      [7:0]              axis_wr_motor,
  output logic      [7:0]              axis_wr_param,
  output logic      [31:0]             axis_wr_data,
  output logic                         glob_wr_valid,
  output logic      [7:0]              glob_wr_bank,
  output logic      [7:0]              glob_wr_param,
  output logic      [31:0]             glob_wr_data,
  output logic                         irq
);

  //====================================================================
  // state
  typedef struct packed {
    acfi_state_type          st;
    logic [3:0]              cnt;
    logic [7:0]              sum;
    logic [7:0]              tgt;
    logic [7:0]              instr;
    logic [7:0]              typ;
    logic [7:0]              bank;
    logic [31:0]             val;
    logic [7:0]              mod_addr;
    logic [31:0]             accu;
    logic [7:0]              rep_status;
    logic [7:0]              rep_instr;
    logic [ACFI_ERR_W-1:0]   err;
    logic [ACFI_NUM_IRQ-1:0] irq_en;
    logic                    irq_glb;
    logic [ACFI_EVT_W-1:0]   evt;
    logic [ACFI_EVT_W-1:0]   mask;
    logic [7:0]              uvar_addr;
    logic                    uvar_we;
    logic [7:0]              uvar_waddr;
    logic [31:0]             uvar_wdata;
    logic                    axis_v;
    logic [7:0]              axis_motor;
    logic [7:0]              axis_param;
    logic [31:0]             axis_data;
    logic                    glob_v;
    logic [7:0]              glob_bank;
    logic [7:0]              glob_param;
    logic [31:0]             glob_data;
    logic [31:0]             prdata;
    logic                    pslverr;
  } acfi_core_state_type;

  acfi_core_state_type q;
  acfi_core_state_type d;

  logic [31:0] uvar_rdata;
  logic        setup_ph;
  logic        wr_acc;
  logic [7:0]  next_sum;
  logic [ACFI_ERR_W-1:0] err_clr;
  logic [ACFI_EVT_W-1:0] evt_hit;

  //====================================================================
  // user variable store
  acfi_uvar_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .we      (q.uvar_we),
    .waddr   (q.uvar_waddr),
    .wdata   (q.uvar_wdata),
    .raddr   (q.uvar_addr),
    .rdata   (uvar_rdata)
  );

  //====================================================================
  // apb decode
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign next_sum = q.sum + pwdata[7:0];

  always_comb begin
    d        = q;
    err_clr  = '0;
    evt_hit  = '0;
    d.axis_v = 1'b0;
    d.glob_v = 1'b0;
    d.uvar_we = 1'b0;

    // read data is latched in setup so it comes from a flip-flop
    if (setup_ph) begin
      d.pslverr = 1'b0;
      d.prdata  = '0;
      case (paddr)
        ACFI_OFS_CTRL:      d.prdata = {24'h000000, q.mod_addr};
        ACFI_OFS_FRAME:     d.prdata = {28'h0000000, q.cnt};
        ACFI_OFS_ACCU:      d.prdata = q.accu;
        ACFI_OFS_REPLY:     d.prdata = {15'h0000, (q.st == ACFI_EXEC),
                                        q.rep_instr, q.rep_status};
        ACFI_OFS_ERR:       d.prdata = {27'h0000000, q.err};
        ACFI_OFS_IRQ_EN:    d.prdata = q.irq_en;
        ACFI_OFS_IRQ_GLB:   d.prdata = {31'h00000000, q.irq_glb};
        ACFI_OFS_EVT_STAT:  d.prdata = {29'h00000000, q.evt};
        ACFI_OFS_EVT_MASK:  d.prdata = {29'h00000000, q.mask};
        ACFI_OFS_UVAR_ADDR: d.prdata = {24'h000000, q.uvar_addr};
        ACFI_OFS_UVAR_DATA: d.prdata = uvar_rdata;
        default:            d.pslverr = 1'b1;
      endcase
    end

    //==================================================================
    // register writes
    if (wr_acc) begin
      case (paddr)
        ACFI_OFS_CTRL: begin
          d.mod_addr = pwdata[7:0];
          // abort drops a partly received frame
          if (pwdata[ACFI_CTRL_ABORT_BIT] && q.st == ACFI_COLLECT) begin
            d.cnt = '0;
            d.sum = '0;
          end
        end
        ACFI_OFS_ACCU:      d.accu = pwdata;
        ACFI_OFS_EVT_STAT:  d.evt = q.evt & ~pwdata[ACFI_EVT_W-1:0];
        ACFI_OFS_EVT_MASK:  d.mask = pwdata[ACFI_EVT_W-1:0];
        ACFI_OFS_UVAR_ADDR: d.uvar_addr = pwdata[7:0];
        ACFI_OFS_FRAME: begin
          // bytes written while a frame executes are ignored
          if (q.st == ACFI_COLLECT) begin
            if (q.cnt == ACFI_FRAME_LAST) begin
              d.cnt = '0;
              d.sum = '0;
              if (q.sum != pwdata[7:0]) begin // RULE_12
                evt_hit[ACFI_EVT_DROP] = 1'b1;
              end else if (q.tgt == q.mod_addr) begin // RULE_13
                d.st = ACFI_EXEC;
              end
            end else begin
              d.sum = next_sum; // RULE_12
              d.cnt = q.cnt + 4'd1;
              case (q.cnt) // RULE_11
                4'd0:    d.tgt = pwdata[7:0];
                4'd1:    d.instr = pwdata[7:0];
                4'd2:    d.typ = pwdata[7:0];
                4'd3:    d.bank = pwdata[7:0];
                4'd4:    d.val[31:24] = pwdata[7:0];
                4'd5:    d.val[23:16] = pwdata[7:0];
                4'd6:    d.val[15:8] = pwdata[7:0];
                default: d.val[7:0] = pwdata[7:0];
              endcase
            end
          end
        end
        default: begin
        end
      endcase
    end

    // a result from the arithmetic unit overrides a software write
    if (accu_load_valid) begin
      d.accu = accu_load_data; // RULE_04
    end

    //==================================================================
    // execution
    case (q.st)
      ACFI_COLLECT: begin
      end
      ACFI_EXEC: begin
        d.st = ACFI_COLLECT;
        d.rep_instr = q.instr;
        d.rep_status = ACFI_STAT_OK; // RULE_10
        evt_hit[ACFI_EVT_REPLY] = 1'b1;
        case (q.instr)
          ACFI_INS_AXIS: begin
            d.axis_v     = 1'b1; // RULE_01
            d.axis_motor = q.bank;
            d.axis_param = q.typ;
            d.axis_data  = q.accu; // RULE_04
          end
          ACFI_INS_GLOBAL: begin
            if (q.bank == ACFI_UVAR_BANK) begin
              d.uvar_we    = 1'b1; // RULE_03
              d.uvar_waddr = q.typ;
              d.uvar_wdata = q.accu;
            end else begin
              d.glob_v     = 1'b1; // RULE_02
              d.glob_bank  = q.bank;
              d.glob_param = q.typ;
              d.glob_data  = q.accu;
            end
          end
          ACFI_INS_CLEAR: begin
            if (q.typ == ACFI_CLE_ALL) begin
              err_clr = '1; // RULE_05
            end else if (q.typ <= ACFI_CLE_MAX) begin
              err_clr[q.typ[2:0] - 3'd1] = 1'b1; // RULE_06
            end else begin
              d.rep_status = ACFI_STAT_BAD_TYPE;
            end
          end
          ACFI_INS_IRQ_EN: begin
            // bank and value bytes are never looked at here
            if (q.typ == ACFI_IRQ_GLOBAL_NUM) begin // RULE_09
              d.irq_glb = 1'b1; // RULE_08
            end else if (q.typ < ACFI_NUM_IRQ[7:0]) begin
              d.irq_en[q.typ[4:0]] = 1'b1; // RULE_07
            end
          end
          default: d.rep_status = ACFI_STAT_BAD_CMD;
        endcase
      end
      default: d.st = ACFI_COLLECT;
    endcase

    //==================================================================
    // sticky flags: a set in the clearing cycle survives
    d.err = (q.err & ~err_clr) | err_set;
    if (|err_set) begin
      evt_hit[ACFI_EVT_ERRSET] = 1'b1;
    end
    d.evt = d.evt | evt_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.st       <= ACFI_COLLECT;
      q.mod_addr <= ACFI_MOD_ADDR_RST;
      q.accu     <= ACFI_ACCU_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  //====================================================================
  // outputs
  assign pready        = ce;
  assign prdata        = q.prdata;
  assign pslverr       = q.pslverr;
  assign err_flags     = q.err;
  assign irq_src_en    = q.irq_en;
  assign irq_global_en = q.irq_glb;
  assign axis_wr_valid = q.axis_v;
  assign axis_wr_motor = q.axis_motor;
  assign axis_wr_param = q.axis_param;
  assign axis_wr_data  = q.axis_data;
  assign glob_wr_valid = q.glob_v;
  assign glob_wr_bank  = q.glob_bank;
  assign glob_wr_param = q.glob_param;
  assign glob_wr_data  = q.glob_data;
  assign irq           = |(q.evt & q.mask);

endmodule

// file: acfi_core_props.sv
module acfi_core_props
  import acfi_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    ce,
  input wire logic [ACFI_ERR_W-1:0]   err_set,
  input wire logic [ACFI_ERR_W-1:0]   err_flags,
  input wire logic [ACFI_NUM_IRQ-1:0] irq_src_en,
  input wire logic                    irq_global_en,
  input wire logic                    axis_wr_valid,
  input wire logic [31:0]             axis_wr_data,
  input wire logic                    glob_wr_valid,
  input wire logic [7:0]              glob_wr_bank
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //==================================================================
  // properties
  property p_axis_pulse; axis_wr_valid && ce |=> !axis_wr_valid; endproperty
  property p_axis_hold; !axis_wr_valid |-> $stable(axis_wr_data); endproperty
  property p_one_kind; !(axis_wr_valid && glob_wr_valid); endproperty
  property p_uvar_bank; glob_wr_valid |-> glob_wr_bank != ACFI_UVAR_BANK; endproperty
  // set wins over a clear in the same cycle
  // a frozen clock enable drops the set, so only running cycles count
  property p_err_set;
    ce && |err_set |=> (err_flags & $past(err_set)) == $past(err_set);
  endproperty
  property p_err_src;
    (err_flags & ~$past(err_flags) & ~$past(err_set)) == '0;
  endproperty
  property p_glb_keep; irq_global_en |=> irq_global_en; endproperty
  property p_src_keep;
    ##1 (irq_src_en & $past(irq_src_en)) == $past(irq_src_en);
  endproperty
  a_axis_pulse: assert property (p_axis_pulse) else $error("axis pulse too long");
  a_axis_hold: assert property (p_axis_hold) else $error("axis data moved");
  a_one_kind: assert property (p_one_kind) else $error("two writes at once");
  a_uvar_bank: assert property (p_uvar_bank) else $error("bank 2 left block");
  a_err_set: assert property (p_err_set) else $error("error flag not set");
  a_err_src: assert property (p_err_src) else $error("error flag from nowhere");
  a_glb_keep: assert property (p_glb_keep) else $error("global enable lost");
  a_src_keep: assert property (p_src_keep) else $error("irq enable lost");
  c_axis: cover property (axis_wr_valid);
  c_glob: cover property (glob_wr_valid);
  c_glb: cover property ($rose(irq_global_en));
endmodule

// file: acfi_far_model.sv
module acfi_far_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [4:0]  err_req,
  input  wire logic        load_req,
  input  wire logic [31:0] load_val,
  output logic      [4:0]  err_set,
  output logic             accu_load_valid,
  output logic      [31:0] accu_load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // stale data is inverted so nothing can lean on a left-over value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_set <= 5'h00;
      accu_load_valid <= 1'b0;
      accu_load_data <= 32'h0;
    end else begin
      err_set <= err_req;
      accu_load_valid <= load_req;
      accu_load_data <= load_req ? load_val : ~accu_load_data;
    end
  end
endmodule

// file: tb.sv
module tb
  import acfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0, axis_wr_motor, axis_wr_param, glob_wr_bank, glob_wr_param;
  logic [31:0] pwdata = 0, prdata, rd, acc, seed = 98895, axis_wr_data, glob_wr_data;
  logic accu_load_valid, load_req = 0, irq_global_en, axis_wr_valid, glob_wr_valid, irq, serr;
  logic [31:0] accu_load_data, load_val = 0, irq_src_en;
  logic [4:0] err_set, err_flags, err_req = 0;
  int bad_count = 0, checked = 0, ax_n = 0, gl_n = 0;
  acfi_core DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .accu_load_valid, .accu_load_data, .err_set, .err_flags, .irq_src_en,
    .irq_global_en, .axis_wr_valid, .axis_wr_motor, .axis_wr_param, .axis_wr_data,
    .glob_wr_valid, .glob_wr_bank, .glob_wr_param, .glob_wr_data, .irq);
  acfi_far_model u_far (.pclk, .presetn, .err_req, .load_req, .load_val, .err_set,
    .accu_load_valid, .accu_load_data);
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (axis_wr_valid === 1'b1) ax_n++;
    if (glob_wr_valid === 1'b1) gl_n++;
  end
  //==================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] csum(input logic [63:0] b);
    logic [7:0] s = 8'h00;
    for (int i = 0; i < 8; i++) s += b[8*i+:8];
    return s;
  endfunction
  function automatic logic [31:0] clr_exp(input int t);
    return (t == 0) ? 32'h0 : 32'h1F & ~(32'h1 << (t - 1));
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task send(input logic [7:0] ad, ins, typ, bnk, input logic [31:0] v, input logic bad);
    logic [71:0] f;
    f = {ad, ins, typ, bnk, v, 8'h00};
    f[7:0] = csum(f[71:8]) ^ {7'h0, bad};
    for (int i = 8; i >= 0; i--) apb(ACFI_OFS_FRAME, 1'b1, {24'h0, f[8*i+:8]}, rd);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //==================================================================
  // tests
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    seed = lfsr(seed);
    acc = seed;
    @(posedge pclk);
    load_req <= 1; load_val <= acc;
    @(posedge pclk);
    load_req <= 0;
    apb(ACFI_OFS_EVT_MASK, 1, 32'h1, rd);
    for (int k = 1; k <= 2; k++) begin
      seed = lfsr(seed);
      send(8'h01, ACFI_INS_AXIS, seed[7:0], seed[15:8], seed, 0);
      chk("axis_cnt", 32'(ax_n), 32'(k));
      chk("axis_data", axis_wr_data, acc);
      chk("axis_sel", {16'h0, axis_wr_motor, axis_wr_param}, {16'h0, seed[15:0]});
    end
    chk("irq_up", {31'h0, irq}, 32'h1);
    apb(ACFI_OFS_REPLY, 0, 0, rd);
    chk("reply", {16'h0, rd[15:0]}, {16'h0, ACFI_INS_AXIS, ACFI_STAT_OK});
    apb(ACFI_OFS_EVT_STAT, 1, 32'h7, rd);
    @(negedge pclk);
    chk("irq_down", {31'h0, irq}, 32'h0);
    $display("test axis done");
    seed = lfsr(seed);
    apb(ACFI_OFS_ACCU, 1, seed, rd);
    send(8'h01, ACFI_INS_GLOBAL, 8'h11, 8'h01, 32'h0, 0);
    chk("glob_data", glob_wr_data, seed);
    chk("glob_sel", {16'h0, glob_wr_bank, glob_wr_param}, 32'h0111);
    send(8'h01, ACFI_INS_GLOBAL, 8'd42, ACFI_UVAR_BANK, 32'h0, 0);
    chk("glob_cnt", 32'(gl_n), 32'h1);
    apb(ACFI_OFS_UVAR_ADDR, 1, 32'd42, rd);
    repeat (2) @(posedge pclk);
    apb(ACFI_OFS_UVAR_DATA, 0, 0, rd);
    chk("uvar", rd, seed);
    apb(ACFI_OFS_ACCU, 0, 0, rd);
    chk("accu", rd, seed);
    $display("test global done");
    for (int t = 0; t <= 5; t++) begin
      @(posedge pclk);
      err_req <= 5'h1F;
      @(posedge pclk);
      err_req <= 5'h00;
      seed = lfsr(seed);
      send(8'h01, ACFI_INS_CLEAR, 8'(t), seed[7:0], seed, 0);
      chk("err_flags", {27'h0, err_flags}, clr_exp(t));
    end
    $display("test clear done");
    seed = lfsr(seed);
    send(8'h01, ACFI_INS_IRQ_EN, 8'd7, seed[7:0], seed, 0);
    chk("irq_src", irq_src_en, 32'h80);
    chk("irq_glb0", {31'h0, irq_global_en}, 32'h0);
    send(8'h01, ACFI_INS_IRQ_EN, ACFI_IRQ_GLOBAL_NUM, 8'h00, 32'h0, 0);
    chk("irq_glb1", {31'h0, irq_global_en}, 32'h1);
    chk("irq_src2", irq_src_en, 32'h80);
    $display("test enable done");
    @(posedge pclk);
    ce <= 0;
    err_req <= 5'h1F;
    @(posedge pclk);
    err_req <= 5'h00;
    repeat (3) @(posedge pclk);
    ce <= 1;
    @(negedge pclk);
    chk("ce_hold", {27'h0, err_flags}, clr_exp(5));
    send(8'h01, ACFI_INS_CLEAR, 8'd6, 8'h00, 32'h0, 0);
    chk("err_keep", {27'h0, err_flags}, clr_exp(5));
    apb(ACFI_OFS_REPLY, 0, 0, rd);
    chk("reply_type", {16'h0, rd[15:0]}, {16'h0, ACFI_INS_CLEAR, ACFI_STAT_BAD_TYPE});
    send(8'h01, 8'h01, 8'h00, 8'h00, 32'h0, 0);
    apb(ACFI_OFS_REPLY, 0, 0, rd);
    chk("reply_cmd", {16'h0, rd[15:0]}, {16'h0, 8'h01, ACFI_STAT_BAD_CMD});
    apb(ACFI_OFS_FRAME, 1, 32'h01, rd);
    apb(ACFI_OFS_FRAME, 1, 32'h22, rd);
    apb(ACFI_OFS_FRAME, 0, 0, rd);
    chk("frame_cnt", rd, 32'h2);
    apb(ACFI_OFS_CTRL, 1, (32'h1 << ACFI_CTRL_ABORT_BIT) | {24'h0, ACFI_MOD_ADDR_RST}, rd);
    apb(ACFI_OFS_FRAME, 0, 0, rd);
    chk("abort", rd, 32'h0);
    apb(ACFI_OFS_CTRL, 0, 0, rd);
    chk("mod_addr", rd, {24'h0, ACFI_MOD_ADDR_RST});
    $display("test misc done");
    send(8'h01, ACFI_INS_AXIS, 8'h00, 8'h00, 32'h0, 1);
    apb(ACFI_OFS_EVT_STAT, 0, 0, rd);
    chk("drop_evt", {31'h0, rd[ACFI_EVT_DROP]}, 32'h1);
    send(8'h05, ACFI_INS_AXIS, 8'h00, 8'h00, 32'h0, 0);
    chk("axis_kept", 32'(ax_n), 32'h2);
    apb(8'h3C, 0, 0, rd);
    chk("unmapped", {31'h0, serr}, 32'h1);
    $display("test refuse done");
    finish_test();
  end
endmodule
bind acfi_core acfi_core_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .err_set(err_set),
  .err_flags(err_flags), .irq_src_en(irq_src_en), .irq_global_en(irq_global_en),
  .axis_wr_valid(axis_wr_valid), .axis_wr_data(axis_wr_data), .glob_wr_valid(glob_wr_valid),
  .glob_wr_bank(glob_wr_bank));
